// ---- spe_defines.svh ----
`ifndef SPE_DEFINES_SVH
`define SPE_DEFINES_SVH

// command opcodes
`define SPE_OP_SET_LATCH 8'h06
`define SPE_OP_CLR_LATCH 8'h04
`define SPE_OP_RD_STATE 8'h05
`define SPE_OP_WR_STATE 8'h01
`define SPE_OP_READ 8'h03
`define SPE_OP_WRITE 8'h02

// status byte bit positions
`define SPE_BIT_PIN_GUARD 7
`define SPE_BIT_GUARD_HIGH 3
`define SPE_BIT_GUARD_LOW 2

// block guard thresholds, 12-bit byte address
`define SPE_GUARD_QUARTER 12'hC00
`define SPE_GUARD_HALF 12'h800

// frame lengths in serial clock rising edges
`define SPE_LEN_OPCODE 6'h08
`define SPE_LEN_STATE_WR 6'h10
`define SPE_LEN_HEADER 6'h18
`define SPE_LEN_FIRST_DATA 6'h20
`define SPE_LEN_SAT 6'h28

// page geometry
`define SPE_PAGE_BYTES 32
`define SPE_PAGE_LAST 5'h1F

// factory value of the non-volatile guard bits
`define SPE_NV_RESET 3'h0

// self-timed write cycle
`define SPE_TWC_MS 5
`define SPE_CLK_KHZ 40000
`define SPE_WC_CYCLES (`SPE_TWC_MS * `SPE_CLK_KHZ)

`endif

// ---- spe_eeprom.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spe_defines.svh"

module spe_eeprom #(
	parameter int unsigned P_WC_CYCLES = `SPE_WC_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_si,
	input wire logic i_hold_n,
	input wire logic i_wp_n,
	output logic o_so,
	output logic o_so_oe
);
	import spe_pkg::*;

	// storage array, written from the system clock, read from the link clock
	logic [7:0] mem [0:4095];

	// system domain state
	spe_sys_e sys_state;
	spe_nv_s nv = `SPE_NV_RESET;
	logic write_latch_flag;
	logic wip;
	logic is_array;
	logic [6:0] page_base;
	logic [31:0] wc_cnt;
	spe_status_s status_q;
	logic cs_m1, cs_s2, cs_s3;
	logic wp_m1, wp_s2;
	logic tog_m1, tog_s2, tog_seen;
	logic commit;
	logic guarded;
	logic pin_guard_on;
	logic take_cmd;
	logic do_set;
	logic do_clr;
	logic do_state;
	logic do_write;
	logic wc_last;

	// link domain state
	logic in_frame;
	logic out_on;
	logic frame_tog;
	logic [5:0] cnt;
	logic [2:0] ph;
	logic [6:0] rx_sr;
	logic [7:0] op;
	logic [3:0] addr_hi;
	logic [11:0] addr;
	logic [11:0] rd_ptr;
	logic [7:0] state_data;
	logic wp_low_seen;
	logic [7:0] page_buf [0:`SPE_PAGE_BYTES-1];
	logic [`SPE_PAGE_BYTES-1:0] page_mask;
	logic [4:0] wptr;
	logic [7:0] tx;
	spe_status_s st_m1, st_s;
	logic [5:0] next_cnt;
	logic [2:0] next_ph;
	logic [7:0] rx_byte;
	logic busy_s;

	// ---------------------------------------------------------------
	// link domain, rising edge: input capture and output byte selection
	// ---------------------------------------------------------------

	// frame position; restarts on the first edge after select falls
	always_comb begin
		next_ph = in_frame ? ph + 3'h1 : 3'h1;
		next_cnt = `SPE_LEN_OPCODE;
		if (!in_frame)
			next_cnt = 6'h01;
		else if (cnt == `SPE_LEN_SAT)
			next_cnt = cnt; // saturates; long reads and pages only need ">= first data"
		else
			next_cnt = cnt + 6'h01;
		rx_byte = {rx_sr, i_si};
	end

	assign busy_s = st_s.wip;

	// frame flags end with the frame's own select, since the link clock stops
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			in_frame <= 1'b0;
			out_on <= 1'b0;
		end else if (i_hold_n) begin
			in_frame <= 1'b1;
			if (next_cnt == `SPE_LEN_OPCODE && next_ph == 3'h0)
				out_on <= (rx_byte == `SPE_OP_RD_STATE);
			else if (next_cnt == `SPE_LEN_HEADER && op == `SPE_OP_READ)
				out_on <= !busy_s; // array reads dropped while busy
		end
	end

	// frame-start event toward the system domain
	always_ff @(posedge i_sck or negedge i_rstn) begin
		if (!i_rstn)
			frame_tog <= 1'b0;
		else if (!i_cs_n && i_hold_n && !in_frame)
			frame_tog <= ~frame_tog;
	end

	// status byte brought over from the system domain
	always_ff @(posedge i_sck) begin
		st_m1 <= status_q;
		st_s <= st_m1;
	end

	// frame position and input shifter; paused edges leave them alone
	always_ff @(posedge i_sck) begin
		if (!i_cs_n && i_hold_n) begin
			cnt <= next_cnt;
			ph <= next_ph;
			rx_sr <= rx_byte[6:0];
		end
	end

	// opcode; payload is not reset by select, the system side reads it after the rise
	always_ff @(posedge i_sck) begin
		if (!i_cs_n && i_hold_n && next_cnt == `SPE_LEN_OPCODE && next_ph == 3'h0)
			op <= rx_byte;
	end

	// guard pin seen low at any edge of the frame, restarted with the opcode
	always_ff @(posedge i_sck) begin
		if (!i_cs_n && i_hold_n) begin
			if (next_cnt == `SPE_LEN_OPCODE && next_ph == 3'h0)
				wp_low_seen <= !i_wp_n;
			else if (!i_wp_n)
				wp_low_seen <= 1'b1;
		end
	end

	// second byte: status data, or the high address byte
	always_ff @(posedge i_sck) begin
		if (!i_cs_n && i_hold_n && next_cnt == `SPE_LEN_STATE_WR && next_ph == 3'h0) begin
			addr_hi <= rx_byte[3:0]; // top four address bits ignored
			state_data <= rx_byte;
		end
	end

	// full start address once the third byte is in
	always_ff @(posedge i_sck) begin
		if (!i_cs_n && i_hold_n && next_cnt == `SPE_LEN_HEADER && next_ph == 3'h0)
			addr <= {addr_hi, rx_byte};
	end

	// page buffer loading; frozen while a write cycle may be reading it
	always_ff @(posedge i_sck) begin
		if (!i_cs_n && i_hold_n && op == `SPE_OP_WRITE && !busy_s) begin
			if (next_cnt == `SPE_LEN_HEADER && next_ph == 3'h0) begin
				wptr <= rx_byte[4:0];
				page_mask <= '0;
			end else if (next_cnt >= `SPE_LEN_FIRST_DATA && next_ph == 3'h0) begin
				page_buf[wptr] <= rx_byte;
				page_mask[wptr] <= 1'b1;
				wptr <= wptr + 5'h01; // wraps inside the page
			end
		end
	end

	// output byte selection at each byte boundary
	always_ff @(posedge i_sck) begin
		if (!i_cs_n && i_hold_n && next_ph == 3'h0) begin
			if (next_cnt == `SPE_LEN_OPCODE) begin
				tx <= st_s;
			end else if (next_cnt == `SPE_LEN_HEADER && op == `SPE_OP_READ) begin
				tx <= mem[{addr_hi, rx_byte}];
				rd_ptr <= {addr_hi, rx_byte} + 12'h001;
			end else if (next_cnt > `SPE_LEN_HEADER && op == `SPE_OP_READ) begin
				tx <= mem[rd_ptr];
				rd_ptr <= rd_ptr + 12'h001; // top of array rolls to zero
			end else if (op == `SPE_OP_RD_STATE) begin
				tx <= st_s; // repeats for as long as the host clocks
			end
		end
	end

	// ---------------------------------------------------------------
	// link domain, falling edge: output shift
	// ---------------------------------------------------------------

	// pause and deselect release the pin at once, not on a clock edge
	always_ff @(negedge i_sck or posedge i_cs_n or negedge i_hold_n) begin
		if (i_cs_n || !i_hold_n) begin
			o_so_oe <= 1'b0;
			o_so <= 1'b0;
		end else begin
			o_so_oe <= out_on;
			o_so <= tx[~ph]; // msb first on falling edges
		end
	end

	// ---------------------------------------------------------------
	// system domain
	// ---------------------------------------------------------------

	// select synchroniser; third flop only serves the rise detector
	always_ff @(posedge i_clk) begin
		cs_m1 <= i_cs_n;
		cs_s2 <= cs_m1;
		cs_s3 <= cs_s2;
	end

	// guard pin synchroniser
	always_ff @(posedge i_clk) begin
		wp_m1 <= i_wp_n;
		wp_s2 <= wp_m1;
	end

	// frame toggle synchroniser; a single bit, so no gray code is needed
	always_ff @(posedge i_clk) begin
		tog_m1 <= frame_tog;
		tog_s2 <= tog_m1;
	end

	// seen copy of the frame toggle; a select rise with no frame does nothing
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			tog_seen <= 1'b0;
		else if (cs_s2 && !cs_s3)
			tog_seen <= tog_s2;
	end

	assign commit = cs_s2 && !cs_s3 && (tog_s2 != tog_seen);
	assign pin_guard_on = nv.pin_guard_enable && (!wp_s2 || wp_low_seen);

	// block guard decode on the 12-bit start address; guards are page aligned
	always_comb begin
		unique case ({nv.block_guard_high, nv.block_guard_low})
			2'b00: guarded = 1'b0;
			2'b01: guarded = (addr >= `SPE_GUARD_QUARTER);
			2'b10: guarded = (addr >= `SPE_GUARD_HALF);
			2'b11: guarded = 1'b1;
		endcase
	end

	// status byte; bits 6..4 read as zero
	always_comb begin
		status_q.pin_guard_enable = nv.pin_guard_enable;
		status_q.zero = 3'h0;
		status_q.block_guard_high = nv.block_guard_high;
		status_q.block_guard_low = nv.block_guard_low;
		status_q.write_latch_flag = write_latch_flag;
		status_q.wip = wip;
	end

	// commit decode; commits in a write cycle are not taken, so commands drop
	assign take_cmd = i_rstn && commit && ph == 3'h0 && sys_state == SYS_IDLE;
	assign do_set = take_cmd && op == `SPE_OP_SET_LATCH && cnt == `SPE_LEN_OPCODE;
	assign do_clr = take_cmd && op == `SPE_OP_CLR_LATCH && cnt == `SPE_LEN_OPCODE;
	assign do_state = take_cmd && op == `SPE_OP_WR_STATE && cnt == `SPE_LEN_STATE_WR
		&& write_latch_flag && !pin_guard_on;
	assign do_write = take_cmd && op == `SPE_OP_WRITE && cnt >= `SPE_LEN_FIRST_DATA
		&& write_latch_flag && !guarded;
	assign wc_last = sys_state == SYS_PROG && wc_cnt == P_WC_CYCLES - 32'h1;

	// write-cycle sequencer
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			sys_state <= SYS_IDLE;
		end else begin
			unique case (sys_state)
				SYS_IDLE: begin
					if (do_state || do_write)
						sys_state <= SYS_PROG;
				end
				SYS_PROG: begin
					if (wc_last)
						sys_state <= SYS_IDLE;
				end
			endcase
		end
	end

	// write latch; the end of a cycle clears it whatever else happens
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			write_latch_flag <= 1'b0;
		else if (wc_last)
			write_latch_flag <= 1'b0;
		else if (do_set)
			write_latch_flag <= 1'b1;
		else if (do_clr)
			write_latch_flag <= 1'b0;
	end

	// busy flag for the whole timed cycle
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			wip <= 1'b0;
		else if (do_state || do_write)
			wip <= 1'b1;
		else if (wc_last)
			wip <= 1'b0;
	end

	// cycle length counter; stands at zero while idle
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			wc_cnt <= 32'h0;
		else if (sys_state == SYS_PROG)
			wc_cnt <= wc_cnt + 32'h1;
		else
			wc_cnt <= 32'h0;
	end

	// what the cycle programs: array page or status only
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			is_array <= 1'b0;
			page_base <= 7'h00;
		end else if (do_state) begin
			is_array <= 1'b0;
		end else if (do_write) begin
			page_base <= addr[11:5];
			is_array <= 1'b1;
		end
	end

	// guard bits; no reset, they model non-volatile cells
	always_ff @(posedge i_clk) begin
		if (do_state) begin
			nv.pin_guard_enable <= state_data[`SPE_BIT_PIN_GUARD];
			nv.block_guard_high <= state_data[`SPE_BIT_GUARD_HIGH];
			nv.block_guard_low <= state_data[`SPE_BIT_GUARD_LOW];
		end
	end

	// array programming, one page slot per cycle at the start of the cycle
	always_ff @(posedge i_clk) begin
		if (sys_state == SYS_PROG && is_array && wc_cnt < `SPE_PAGE_BYTES
			&& page_mask[wc_cnt[4:0]])
			mem[{page_base, wc_cnt[4:0]}] <= page_buf[wc_cnt[4:0]];
	end

endmodule // spe_eeprom
`default_nettype wire

// ---- spe_eeprom_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module spe_eeprom_asserts (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_si,
	input wire logic i_hold_n,
	input wire logic i_wp_n,
	input wire logic o_so,
	input wire logic o_so_oe
);
	logic [7:0] cnt;
	logic [7:0] op;
	logic so_rise;

	// frame bit count and opcode; deselect clears them just as it ends a frame
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			cnt <= 8'h00;
			op <= 8'h00;
		end else if (i_hold_n) begin
			cnt <= cnt + 8'h01;
			if (cnt < 8'h08) op <= {op[6:0], i_si};
		end
	end

	// output seen at a rising edge must last until the falling edge
	always_ff @(posedge i_sck) begin
		so_rise <= o_so;
	end

	a_cs_high_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_cs_n |-> !o_so_oe && !o_so) else $error("output driven while deselected");
	a_hold_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!i_hold_n |-> !o_so_oe) else $error("output driven during pause");
	a_opcode_silent: assert property (@(posedge i_sck) disable iff (i_cs_n)
		cnt < 8'h08 |-> !o_so_oe) else $error("output driven during opcode");
	a_state_answer: assert property (@(posedge i_sck) disable iff (i_cs_n)
		op == 8'h05 && cnt >= 8'h08 |-> o_so_oe) else $error("status not driven");
	a_bad_op_silent: assert property (@(posedge i_sck) disable iff (i_cs_n)
		cnt >= 8'h08 && !(op inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02}) |-> !o_so_oe)
		else $error("unknown opcode drives output");
	a_out_on_fall: assert property (@(negedge i_sck) disable iff (i_cs_n)
		o_so_oe |-> o_so == so_rise) else $error("output changed on rising edge");
	a_status_zeros: assert property (@(posedge i_sck) disable iff (i_cs_n)
		op == 8'h05 && cnt >= 8'h08 && cnt[2:0] inside {3'h1, 3'h2, 3'h3} |-> !o_so)
		else $error("status bits 6 to 4 not zero");
	a_addr_silent: assert property (@(posedge i_sck) disable iff (i_cs_n)
		(op == 8'h03 && cnt < 8'h18) || op inside {8'h01, 8'h02, 8'h04, 8'h06} |-> !o_so_oe)
		else $error("output driven before data phase");
endmodule // spe_eeprom_asserts

bind spe_eeprom spe_eeprom_asserts u_asserts (.i_clk(i_clk), .i_rstn(i_rstn), .i_sck(i_sck),
	.i_cs_n(i_cs_n), .i_si(i_si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(o_so),
	.o_so_oe(o_so_oe));
`default_nettype wire

// ---- spe_eeprom_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module spe_eeprom_bench;
	localparam int WC = 200;
	logic clk = 1'b0;
	logic rstn;
	logic wp_n = 1'b1;
	logic sck, cs_n, si, hold_n, so, so_oe;
	int mismatches = 0;
	int num_checks = 0;
	logic [71:0] r;
	logic [11:0] a;
	logic ok;
	logic [12:0] base [4] = '{13'h1000, 13'h0C00, 13'h0800, 13'h0000};
	logic [7:0] bad [4] = '{8'h00, 8'h07, 8'hFF, 8'h85};

	// short write cycle keeps polling brief
	always #12.5 clk = ~clk;

	spe_eeprom #(.P_WC_CYCLES(WC)) u_dut (.i_clk(clk), .i_rstn(rstn), .i_sck(sck),
		.i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so),
		.o_so_oe(so_oe));
	spe_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n),
		.i_so(so), .i_so_oe(so_oe));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic go(input logic [71:0] d, input int n);
		u_host.xfer(d, n, -1, r);
	endtask

	task automatic stat(input logic [7:0] exp, input string what);
		go(72'h0500, 16);
		check(what, r[7:0], exp);
	endtask

	// poll the busy bit under a bounded count
	task automatic poll;
		int k;
		k = 0;
		r = 72'h1;
		while (r[0] !== 1'b0 && k < 40) begin
			go(72'h0500, 16);
			k++;
		end
		check("busy end", {7'h00, r[0]}, 8'h00);
	endtask

	task automatic rd(input logic [15:0] ad, input logic [15:0] e);
		u_host.xfer({8'h03, ad, 16'h0000}, 40, -1, r);
		check("read hi", r[15:8], e[15:8]);
		check("read lo", r[7:0], e[7:0]);
	endtask

	task automatic reset_dut;
		@(negedge clk) rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
	endtask

	// hang guard, far beyond the expected run time
	initial begin
		#500000;
		mismatches++;
		finish_test;
	end

	initial begin
		reset_dut;
		stat(8'h00, "power up");
		go(8'h06, 8);
		stat(8'h02, "latch set");
		go(8'h04, 8);
		stat(8'h00, "latch clear");
		go({8'h06, 8'h00}, 16);
		stat(8'h00, "long latch frame");
		go({8'h02, 16'h0123, 8'h5A}, 32);
		stat(8'h00, "write no latch");
		$display("test latch done");
		go(8'h06, 8);
		go({8'h02, 16'h001E, 8'h11, 8'h22, 8'h33}, 48);
		poll;
		go(8'h06, 8);
		go({8'h02, 16'hAFFF, 8'h5A}, 32);
		stat(8'h03, "busy");
		go(8'h04, 8);
		go({8'h03, 16'h001E, 8'h00}, 32);
		check("read busy", r[7:0], 8'hXX);
		stat(8'h03, "busy ignores");
		poll;
		stat(8'h00, "write done");
		rd(16'hF01E, 16'h1122);
		rd(16'h0FFF, 16'h5A33);
		$display("test array done");
		for (int g = 0; g < 4; g++) begin
			go(8'h06, 8);
			go({8'h01, 1'b0, 3'h7, g[1:0], 2'h3}, 16);
			poll;
			stat({4'h0, g[1:0], 2'h0}, "guard set");
			for (int k = 0; k < 2; k++) begin
				a = base[g][11:0] - 12'(1 - k);
				ok = {1'b0, a} < base[g];
				go(8'h06, 8);
				go({8'h02, 4'h0, a, 8'hC3}, 32);
				stat({4'h0, g[1:0], 1'b1, ok}, "guarded write");
				if (ok) poll;
				else go(8'h04, 8);
			end
		end
		$display("test guard done");
		go(8'h06, 8);
		go({8'h01, 8'h8C}, 16);
		poll;
		@(negedge clk) wp_n = 1'b0;
		go(8'h06, 8);
		go({8'h01, 8'h00}, 16);
		stat(8'h8E, "pin refused");
		@(negedge clk) wp_n = 1'b1;
		fork
			go({8'h01, 8'h80}, 16);
			begin
				#200;
				@(negedge clk) wp_n = 1'b0;
			end
		join
		stat(8'h8E, "pin abort");
		@(negedge clk) wp_n = 1'b1;
		reset_dut;
		stat(8'h8C, "kept over reset");
		go(8'h06, 8);
		go({8'h01, 8'h00}, 16);
		poll;
		stat(8'h00, "guards cleared");
		$display("test pin guard done");
		foreach (bad[j]) begin
			go({bad[j], 8'h00}, 16);
			check("bad opcode", r[7:0], 8'hXX);
		end
		u_host.xfer(72'h0500, 16, 12, r);
		check("paused read", r[7:0], 8'h00);
		$display("test opcode and pause done");
		finish_test;
	end
endmodule // spe_eeprom_bench
`default_nettype wire

// ---- spe_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module spe_host (
	output logic o_sck,
	output logic o_cs_n,
	output logic o_si,
	output logic o_hold_n,
	input wire logic i_so,
	input wire logic i_so_oe
);
	// serial clock idles low between frames, mode (0,0)
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
		o_hold_n = 1'b1;
	end

	// one framed transfer, n whole bits, msb first; undriven output reads unknown
	task automatic xfer(input logic [71:0] d, input int n, input int hold_at,
		output logic [71:0] r);
		r = 72'h0;
		o_cs_n = 1'b0;
		#20;
		for (int i = n - 1; i >= 0; i--) begin
			o_si = d[i];
			if (i == hold_at) begin
				o_hold_n = 1'b0; // pause only with clock low
				#10 o_si = ~o_si;
				#10 o_si = d[i];
				#10 o_hold_n = 1'b1;
			end
			#15 o_sck = 1'b1;
			r = {r[70:0], i_so_oe ? i_so : 1'bx};
			#15 o_sck = 1'b0;
		end
		#15 o_cs_n = 1'b1; // rise right after the last whole byte
		o_si = ~o_si;
		#150;
	endtask
endmodule // spe_host
`default_nettype wire

// ---- spe_pkg.sv ----
package spe_pkg;

	// write-cycle sequencer of the system clock domain
	typedef enum logic {SYS_IDLE, SYS_PROG} spe_sys_e;

	// status byte as the host sees it
	typedef struct packed {
		logic pin_guard_enable;
		logic [2:0] zero;
		logic block_guard_high;
		logic block_guard_low;
		logic write_latch_flag;
		logic wip;
	} spe_status_s;

	// non-volatile part of the status byte
	typedef struct packed {
		logic pin_guard_enable;
		logic block_guard_high;
		logic block_guard_low;
	} spe_nv_s;

endpackage
